// file: ecl_chan_counter.sv
`default_nettype none
`include "ecl_defines.svh"
module ecl_chan_counter (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire ecl_pkg::ecl_edge_t edge_mode,
  input wire logic rise,
  input wire logic fall,
  input wire logic wr_en,
  input wire ecl_pkg::ecl_word_t wr_data,
  output logic [15:0] count,
  output logic wrapped
);
  import ecl_pkg::*;
  logic [15:0] count_ff;
  logic [15:0] nxt_count;
  logic step;

  // only a single selected polarity counts
  always_comb begin
    step = ((edge_mode == ECL_EDGE_FALL) && fall) ||
           ((edge_mode == ECL_EDGE_RISE) && rise);
    nxt_count = count_ff;
    wrapped = 1'b0;
    if (wr_en) begin
      nxt_count = wr_data;
    end else if (step) begin
      nxt_count = count_ff + `ECL_ONE16;
      wrapped = (count_ff == `ECL_MAX16);
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      count_ff <= `ECL_ZERO16;
    end else begin
      count_ff <= nxt_count;
    end
  end

  assign count = count_ff;

  a_count_step: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (!wr_en && edge_mode == ECL_EDGE_RISE && rise) |=>
      count_ff == $past(count_ff) + `ECL_ONE16)
    else $error("counter did not step on selected edge");
  a_both_idle: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (!wr_en && (edge_mode == ECL_EDGE_BOTH || edge_mode == ECL_EDGE_OFF))
      |=> $stable(count_ff))
    else $error("counter moved with both or no edge selected");
  a_preset_load: assert property (@(posedge ref_clk) disable iff (!arst_n)
    wr_en |=> count_ff == $past(wr_data))
    else $error("counter preset not loaded");
endmodule
`default_nettype wire

// file: ecl_defines.svh
`ifndef ECL_DEFINES_SVH
`define ECL_DEFINES_SVH
// register byte offsets
`define ECL_OFS_WRAP0 12'h018
`define ECL_OFS_WRAP3 12'h01e
`define ECL_OFS_CNT_BASE 12'h0a0
`define ECL_OFS_CNT_END 12'h120
`define ECL_OFS_STAMP 12'h120
`define ECL_OFS_LIMIT 12'h122
`define ECL_OFS_TALLY 12'h124
`define ECL_OFS_SNAP 12'h126
`define ECL_OFS_AC 12'h128
`define ECL_OFS_LAMP 12'h800
`define ECL_OFS_HAND 12'h802
// reset values and limits
`define ECL_AC_RESET 16'h0005
`define ECL_ZERO16 16'h0000
`define ECL_ONE16 16'h0001
`define ECL_MAX16 16'hffff
`define ECL_LOG_SLOTS 16'h0c00
// time stamp rate
`define ECL_CLK_KHZ 25000
`define ECL_STAMP_MS 1
`endif

// file: ecl_event_log.sv
`default_nettype none
`include "ecl_defines.svh"
module ecl_event_log (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic evt,
  input wire logic handover,
  input wire logic tally_wr,
  input wire logic snap_wr,
  input wire ecl_pkg::ecl_word_t wr_data,
  input wire ecl_pkg::ecl_word_t limit,
  output logic [15:0] tally,
  output logic [15:0] snapshot,
  output logic [15:0] slot,
  output logic limit_hit
);
  import ecl_pkg::*;
  logic [15:0] tally_ff;
  logic [15:0] snap_ff;
  logic [15:0] nxt_tally;
  logic [15:0] nxt_snap;
  logic [15:0] stepped;

  // tally step with wrap at the end of the buffer
  always_comb begin
    stepped = (tally_ff == `ECL_LOG_SLOTS) ? `ECL_ZERO16
              : tally_ff + `ECL_ONE16;
    slot = (tally_ff == `ECL_LOG_SLOTS) ? `ECL_ZERO16 : tally_ff;
    nxt_tally = tally_ff;
    nxt_snap = snap_ff;
    limit_hit = 1'b0;
    if (handover) begin
      nxt_snap = tally_ff;
      nxt_tally = evt ? `ECL_ONE16 : `ECL_ZERO16;
    end else if (tally_wr) begin
      nxt_tally = wr_data;
    end else if (evt) begin
      nxt_tally = stepped;
      limit_hit = (stepped == limit);
    end
    if (snap_wr && !handover) begin
      nxt_snap = wr_data;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      tally_ff <= `ECL_ZERO16;
      snap_ff <= `ECL_ZERO16;
    end else begin
      tally_ff <= nxt_tally;
      snap_ff <= nxt_snap;
    end
  end

  assign tally = tally_ff;
  assign snapshot = snap_ff;

  a_handover_snap: assert property (@(posedge ref_clk) disable iff (!arst_n)
    handover |=> snap_ff == $past(tally_ff) && tally_ff <= `ECL_ONE16)
    else $error("handover did not snapshot and clear tally");
  a_tally_wrap: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (evt && !handover && !tally_wr && tally_ff == `ECL_LOG_SLOTS)
      |=> tally_ff == `ECL_ZERO16)
    else $error("tally did not wrap at buffer end");
endmodule
`default_nettype wire

// file: ecl_host.sv
`default_nettype none
`include "ecl_defines.svh"
module ecl_host (
  input wire logic ref_clk,
  output var logic [11:0] reg_addr,
  output var logic reg_wr,
  output var logic reg_rd,
  output var ecl_pkg::ecl_word_t reg_wdata,
  input wire logic [15:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  import ecl_pkg::*;
  // bus idle at time zero
  initial begin
    reg_addr = 12'h000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 16'h0000;
  end
  // one write; released data no longer shows the old value
  task automatic wr(input logic [11:0] a, input ecl_word_t d);
    @(posedge ref_clk);
    #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge ref_clk);
    #1;
    reg_wr = 1'b0;
    reg_wdata = ~d;
  endtask
  // one read; data sampled once the registered answer has landed
  task automatic rd(input logic [11:0] a, output ecl_word_t d);
    @(posedge ref_clk);
    #1;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge ref_clk);
    #1;
    reg_rd = 1'b0;
    @(posedge ref_clk);
    #1;
    d = reg_rdata;
  endtask
  // limit kept within the storable slots
  task automatic set_limit(input ecl_word_t lim);
    wr(`ECL_OFS_LIMIT, (lim > `ECL_LOG_SLOTS) ? `ECL_LOG_SLOTS : lim);
  endtask
  // alternating input setup word
  task automatic ac_prepare();
    wr(`ECL_OFS_AC, 16'h0005);
  endtask
endmodule
`default_nettype wire

// file: ecl_pkg.sv
`default_nettype none
package ecl_pkg;
  // edge selection of one channel
  typedef enum logic [1:0] {
    ECL_EDGE_OFF = 2'b00,
    ECL_EDGE_FALL = 2'b01,
    ECL_EDGE_RISE = 2'b10,
    ECL_EDGE_BOTH = 2'b11
  } ecl_edge_t;
  typedef logic [15:0] ecl_word_t;
endpackage
`default_nettype wire

// file: ecl_regs.sv
`default_nettype none
`include "ecl_defines.svh"
module ecl_regs #(
  parameter int CHANNELS = 64,
  parameter int TICK_CYCLES = `ECL_CLK_KHZ * `ECL_STAMP_MS
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic [11:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire ecl_pkg::ecl_word_t reg_wdata,
  output logic [15:0] reg_rdata,
  input wire ecl_pkg::ecl_edge_t edge_mode [CHANNELS],
  input wire logic [CHANNELS-1:0] in_rise,
  input wire logic [CHANNELS-1:0] in_fall,
  input wire logic test_mode,
  input wire logic lamp_ctrl,
  input wire logic stamp_irq_en,
  input wire logic limit_irq_en,
  input wire logic [2:0] flag_clr,
  output logic wrap_flag,
  output logic stamp_flag,
  output logic limit_flag,
  output logic irq,
  output logic lamp_on,
  output logic [15:0] ac_setup,
  output logic log_bank,
  output logic log_wr,
  output logic [15:0] log_slot,
  output logic [15:0] log_stamp,
  output logic [7:0] log_chan,
  output logic log_level
);
  import ecl_pkg::*;

  if (CHANNELS != 64) begin : g_bad_ch
    $error("ecl_regs serves exactly 64 channels");
  end
  if (TICK_CYCLES < 2) begin : g_bad_tick
    $error("ecl_regs needs TICK_CYCLES of at least 2");
  end

  localparam int TW = $clog2(TICK_CYCLES);

  // decoded accesses
  logic cnt_hit;
  logic [5:0] cnt_idx;
  logic [11:0] cnt_ofs;
  logic wr_stamp;
  logic wr_limit;
  logic wr_tally;
  logic wr_snap;
  logic wr_ac;
  logic wr_lamp;
  logic wr_hand;
  logic [3:0] wr_wrap;

  always_comb begin
    cnt_ofs = reg_addr - `ECL_OFS_CNT_BASE;
    cnt_hit = (reg_addr >= `ECL_OFS_CNT_BASE) &&
              (reg_addr < `ECL_OFS_CNT_END) && !reg_addr[0];
    cnt_idx = cnt_ofs[6:1];
    wr_stamp = reg_wr && (reg_addr == `ECL_OFS_STAMP);
    wr_limit = reg_wr && (reg_addr == `ECL_OFS_LIMIT);
    wr_tally = reg_wr && (reg_addr == `ECL_OFS_TALLY);
    wr_snap = reg_wr && (reg_addr == `ECL_OFS_SNAP);
    wr_ac = reg_wr && (reg_addr == `ECL_OFS_AC);
    wr_lamp = reg_wr && (reg_addr == `ECL_OFS_LAMP);
    wr_hand = reg_wr && (reg_addr == `ECL_OFS_HAND);
    for (int k = 0; k < 4; k++) begin
      wr_wrap[k] = reg_wr &&
        (reg_addr == `ECL_OFS_WRAP0 + 12'(2 * k));
    end
  end

  // per-channel counters
  logic [15:0] cnt_val [CHANNELS];
  logic [CHANNELS-1:0] cnt_wrapped;
  for (genvar c = 0; c < CHANNELS; c++) begin : g_ch
    ecl_chan_counter u_cnt (
      .ref_clk(ref_clk),
      .arst_n(arst_n),
      .edge_mode(edge_mode[c]),
      .rise(in_rise[c]),
      .fall(in_fall[c]),
      .wr_en(reg_wr && cnt_hit && (cnt_idx == 6'(c))),
      .wr_data(reg_wdata),
      .count(cnt_val[c]),
      .wrapped(cnt_wrapped[c])
    );
  end

  // wrap flag registers, word k holds channels 63-16k down to 48-16k
  logic [CHANNELS-1:0] wrap_ff;
  logic [CHANNELS-1:0] nxt_wrap;
  always_comb begin
    nxt_wrap = wrap_ff;
    for (int k = 0; k < 4; k++) begin
      if (wr_wrap[k]) begin
        nxt_wrap[16*(3-k) +: 16] = wrap_ff[16*(3-k) +: 16] & ~reg_wdata;
      end
    end
    nxt_wrap = nxt_wrap | cnt_wrapped;
  end

  // millisecond stamp counter with prescaler
  logic [TW-1:0] pre_ff;
  logic [TW-1:0] nxt_pre;
  logic [15:0] stamp_ff;
  logic [15:0] nxt_stamp;
  logic tick;
  logic stamp_max;
  always_comb begin
    tick = (pre_ff == TW'(TICK_CYCLES - 1));
    nxt_pre = tick ? '0 : pre_ff + TW'(1);
    nxt_stamp = stamp_ff;
    stamp_max = 1'b0;
    if (wr_stamp && !test_mode) begin
      nxt_stamp = reg_wdata;
    end else if (tick) begin
      nxt_stamp = stamp_ff + `ECL_ONE16;
      stamp_max = (nxt_stamp == `ECL_MAX16);
    end
  end

  // event gathering: lowest channel is logged, tally steps once per cycle however many channels fire
  logic evt;
  logic [7:0] evt_chan;
  logic evt_level;
  always_comb begin
    evt = 1'b0;
    evt_chan = 8'h00;
    evt_level = 1'b0;
    for (int c = CHANNELS - 1; c >= 0; c--) begin
      if ((in_rise[c] && edge_mode[c][1]) ||
          (in_fall[c] && edge_mode[c][0])) begin
        evt = 1'b1;
        evt_chan = 8'(c);
        evt_level = in_rise[c];
      end
    end
  end

  logic [15:0] limit_ff;
  logic [15:0] tally_val;
  logic [15:0] snap_val;
  logic [15:0] slot_val;
  logic limit_hit;
  ecl_event_log u_log (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .evt(evt),
    .handover(wr_hand),
    .tally_wr(wr_tally),
    .snap_wr(wr_snap),
    .wr_data(reg_wdata),
    .limit(limit_ff),
    .tally(tally_val),
    .snapshot(snap_val),
    .slot(slot_val),
    .limit_hit(limit_hit)
  );

  // sticky flags, set wins over clear
  logic wflag_ff;
  logic sflag_ff;
  logic lflag_ff;
  logic nxt_wflag;
  logic nxt_sflag;
  logic nxt_lflag;
  logic [15:0] nxt_limit;
  logic [15:0] ac_ff;
  logic [15:0] nxt_ac;
  logic lamp_force_ff;
  logic nxt_lamp_force;
  logic lamp_ff;
  logic nxt_lamp;
  logic bank_ff;
  logic nxt_bank;
  always_comb begin
    nxt_wflag = (|cnt_wrapped) || (wflag_ff && !flag_clr[0]);
    nxt_sflag = stamp_max || (sflag_ff && !flag_clr[1]);
    nxt_lflag = limit_hit || (lflag_ff && !flag_clr[2]);
    nxt_limit = wr_limit ? reg_wdata : limit_ff;
    nxt_ac = wr_ac ? reg_wdata : ac_ff;
    nxt_lamp_force = lamp_force_ff || wr_lamp;
    nxt_lamp = nxt_lamp_force || lamp_ctrl;
    nxt_bank = bank_ff ^ wr_hand;
  end

  // log entry outputs
  logic log_wr_ff;
  logic [15:0] log_slot_ff;
  logic [15:0] log_stamp_ff;
  logic [7:0] log_chan_ff;
  logic log_level_ff;

  // register read mux
  logic [15:0] nxt_rdata;
  logic [15:0] rdata_ff;
  always_comb begin
    nxt_rdata = `ECL_ZERO16;
    if (cnt_hit) begin
      nxt_rdata = cnt_val[cnt_idx];
    end else begin
      case (reg_addr)
        `ECL_OFS_STAMP: nxt_rdata = stamp_ff;
        `ECL_OFS_LIMIT: nxt_rdata = limit_ff;
        `ECL_OFS_TALLY: nxt_rdata = tally_val;
        `ECL_OFS_SNAP: nxt_rdata = snap_val;
        `ECL_OFS_AC: nxt_rdata = ac_ff;
        default: begin
          for (int k = 0; k < 4; k++) begin
            if (reg_addr == `ECL_OFS_WRAP0 + 12'(2 * k)) begin
              nxt_rdata = wrap_ff[16*(3-k) +: 16];
            end
          end
        end
      endcase
    end
    if (!reg_rd) begin
      nxt_rdata = rdata_ff;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      wrap_ff <= '0;
      pre_ff <= '0;
      stamp_ff <= `ECL_ZERO16;
      limit_ff <= `ECL_ZERO16;
      ac_ff <= `ECL_AC_RESET;
      wflag_ff <= 1'b0;
      sflag_ff <= 1'b0;
      lflag_ff <= 1'b0;
      lamp_force_ff <= 1'b0;
      lamp_ff <= 1'b0;
      bank_ff <= 1'b0;
      rdata_ff <= `ECL_ZERO16;
      log_wr_ff <= 1'b0;
      log_slot_ff <= `ECL_ZERO16;
      log_stamp_ff <= `ECL_ZERO16;
      log_chan_ff <= 8'h00;
      log_level_ff <= 1'b0;
    end else begin
      wrap_ff <= nxt_wrap;
      pre_ff <= nxt_pre;
      stamp_ff <= nxt_stamp;
      limit_ff <= nxt_limit;
      ac_ff <= nxt_ac;
      wflag_ff <= nxt_wflag;
      sflag_ff <= nxt_sflag;
      lflag_ff <= nxt_lflag;
      lamp_force_ff <= nxt_lamp_force;
      lamp_ff <= nxt_lamp;
      bank_ff <= nxt_bank;
      rdata_ff <= nxt_rdata;
      log_wr_ff <= evt;
      log_slot_ff <= slot_val;
      log_stamp_ff <= stamp_ff;
      log_chan_ff <= evt_chan;
      log_level_ff <= evt_level;
    end
  end

  // outputs
  assign reg_rdata = rdata_ff;
  assign wrap_flag = wflag_ff;
  assign stamp_flag = sflag_ff;
  assign limit_flag = lflag_ff;
  assign irq = (sflag_ff && stamp_irq_en) || (lflag_ff && limit_irq_en);
  assign lamp_on = lamp_ff;
  assign ac_setup = ac_ff;
  assign log_bank = bank_ff;
  assign log_wr = log_wr_ff;
  assign log_slot = log_slot_ff;
  assign log_stamp = log_stamp_ff;
  assign log_chan = log_chan_ff;
  assign log_level = log_level_ff;

  a_lamp_forced: assert property (@(posedge ref_clk) disable iff (!arst_n)
    lamp_force_ff |=> lamp_on && lamp_force_ff)
    else $error("forced lamp went off without reset");
  a_lamp_write: assert property (@(posedge ref_clk) disable iff (!arst_n)
    wr_lamp |=> ##1 lamp_on)
    else $error("lamp write did not force lamp on");
  a_stamp_locked: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (wr_stamp && test_mode && !tick) |=> $stable(stamp_ff))
    else $error("stamp preset taken in test mode");
  a_stamp_tick: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (tick && !wr_stamp) |=> stamp_ff == $past(stamp_ff) + `ECL_ONE16)
    else $error("stamp did not advance on millisecond tick");
  a_stamp_flag: assert property (@(posedge ref_clk) disable iff (!arst_n)
    stamp_max |=> sflag_ff ##0 (irq == (stamp_irq_en || limit_irq_en
      && lflag_ff) || !stamp_irq_en))
    else $error("stamp maximum did not raise flag");
  a_wrap_sticky: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (|cnt_wrapped) |=> wflag_ff && ((wrap_ff & $past(cnt_wrapped))
      == $past(cnt_wrapped)))
    else $error("counter wrap flag not set");
  a_limit_flag: assert property (@(posedge ref_clk) disable iff (!arst_n)
    limit_hit |=> lflag_ff && tally_val == limit_ff)
    else $error("limit reach not flagged");
endmodule
`default_nettype wire

// file: tb_top.sv
`default_nettype none
`include "ecl_defines.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import ecl_pkg::*;
  localparam int TICKS = 4;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [11:0] reg_addr;
  logic reg_wr;
  logic reg_rd;
  ecl_word_t reg_wdata;
  logic [15:0] reg_rdata;
  ecl_edge_t edge_mode [64];
  logic [63:0] in_rise = '0;
  logic [63:0] in_fall = '0;
  logic test_mode = 1'b0;
  logic lamp_ctrl = 1'b0;
  logic stamp_irq_en = 1'b0;
  logic limit_irq_en = 1'b0;
  logic [2:0] flag_clr = '0;
  logic wrap_flag, stamp_flag, limit_flag, irq, lamp_on;
  logic log_bank, log_wr, log_level;
  logic [15:0] ac_setup, log_slot, log_stamp;
  logic [7:0] log_chan;
  int mismatches = 0;
  int num_checks = 0;
  int cycles = 0;
  int cnt_m [64];
  int tally_m = 0;
  logic [24:0] logq [$];
  ecl_word_t d;
  logic bank0;
  ecl_word_t v;
  int pre_m = 0;
  int stamp_m = 0;
  int stamp_q = 0;

  ecl_host i_host (.ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
  ecl_regs #(.TICK_CYCLES(TICKS)) i_dut (.ref_clk(ref_clk), .arst_n(arst_n),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .edge_mode(edge_mode),
    .in_rise(in_rise), .in_fall(in_fall), .test_mode(test_mode),
    .lamp_ctrl(lamp_ctrl), .stamp_irq_en(stamp_irq_en),
    .limit_irq_en(limit_irq_en), .flag_clr(flag_clr),
    .wrap_flag(wrap_flag), .stamp_flag(stamp_flag),
    .limit_flag(limit_flag), .irq(irq), .lamp_on(lamp_on),
    .ac_setup(ac_setup), .log_bank(log_bank), .log_wr(log_wr),
    .log_slot(log_slot), .log_stamp(log_stamp), .log_chan(log_chan),
    .log_level(log_level));

  // clock, hang guard and log entry capture
  always #20 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      conclude();
    end
  end
  always @(posedge ref_clk) begin
    if (log_wr === 1'b1) begin
      logq.push_back({log_slot, log_chan, log_level});
      chk("log stamp", 16'(stamp_q), log_stamp);
    end
  end

  // stamp model: one count per TICKS clocks, host preset outside test mode
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pre_m <= 0;
      stamp_m <= 0;
      stamp_q <= 0;
    end else begin
      stamp_q <= stamp_m;
      pre_m <= (pre_m == TICKS - 1) ? 0 : pre_m + 1;
      if (reg_wr === 1'b1 && reg_addr == `ECL_OFS_STAMP &&
          !test_mode) begin
        stamp_m <= int'(reg_wdata);
      end else if (pre_m == TICKS - 1) begin
        stamp_m <= (stamp_m + 1) % 65536;
      end
    end
  end

  task automatic conclude();
    if (mismatches == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(string nm, logic [15:0] exp, logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic flag_pulse(input logic [2:0] f);
    @(posedge ref_clk);
    #1;
    flag_clr = f;
    @(posedge ref_clk);
    #1;
    flag_clr = 3'b000;
  endtask

  // one input change, then counter, log entry and tally against the model
  task automatic pulse(input int ch, input logic up);
    logic [24:0] e;
    logic sel;
    ecl_edge_t m;
    m = edge_mode[ch];
    sel = (m == ECL_EDGE_BOTH) || (m == (up ? ECL_EDGE_RISE : ECL_EDGE_FALL));
    @(posedge ref_clk);
    #1;
    in_rise[ch] = up;
    in_fall[ch] = !up;
    @(posedge ref_clk);
    #1;
    in_rise = '0;
    in_fall = '0;
    repeat (3) @(posedge ref_clk);
    if (sel && m != ECL_EDGE_BOTH) cnt_m[ch] = (cnt_m[ch] + 1) % 65536;
    chk("log count", 16'(sel), 16'(logq.size()));
    if (sel && logq.size() > 0) begin
      e = logq.pop_front();
      chk("log slot", 16'(tally_m % 3072), e[24:9]);
      chk("log chan", 16'(ch), {8'h00, e[8:1]});
      chk("log level", {15'h0, up}, {15'h0, e[0]});
      tally_m = (tally_m == 3072) ? 0 : tally_m + 1;
    end
    #1;
    i_host.rd(`ECL_OFS_CNT_BASE + 12'(2 * ch), d);
    chk("counter", 16'(cnt_m[ch]), d);
    i_host.rd(`ECL_OFS_TALLY, d);
    chk("tally", 16'(tally_m), d);
  endtask

  initial begin
    int ch;
    foreach (edge_mode[i]) edge_mode[i] = ECL_EDGE_OFF;
    void'($urandom(32'h266f));
    repeat (3) @(posedge ref_clk);
    #1;
    arst_n = 1'b1;
    chk("ac setup", `ECL_AC_RESET, ac_setup);
    chk("lamp", 16'h0, {15'h0, lamp_on});
    i_host.rd(`ECL_OFS_TALLY, d);
    chk("tally", 16'h0, d);
    i_host.rd(`ECL_OFS_SNAP, d);
    chk("snapshot", 16'h0, d);
    i_host.rd(`ECL_OFS_LIMIT, d);
    chk("limit", 16'h0, d);
    v = 16'($urandom);
    i_host.wr(`ECL_OFS_AC, v);
    chk("ac write", v, ac_setup);
    i_host.ac_prepare();
    i_host.rd(`ECL_OFS_AC, d);
    chk("ac read", `ECL_AC_RESET, d);
    // every edge mode on a random channel preset to a random count
    for (int m = 0; m < 4; m++) begin
      ch = int'($urandom_range(63));
      edge_mode[ch] = ecl_edge_t'(2'(m));
      cnt_m[ch] = int'($urandom_range(65534));
      i_host.wr(`ECL_OFS_CNT_BASE + 12'(2 * ch), 16'(cnt_m[ch]));
      pulse(ch, 1'b1);
      pulse(ch, 1'b0);
    end
    // counter wrap sets channel bit and summary; both clear
    edge_mode[5] = ECL_EDGE_RISE;
    cnt_m[5] = 65535;
    i_host.wr(`ECL_OFS_CNT_BASE + 12'h00a, 16'hffff);
    pulse(5, 1'b1);
    chk("wrap flag", 16'h1, {15'h0, wrap_flag});
    i_host.rd(`ECL_OFS_WRAP3, d);
    chk("wrap bit", 16'h0020, d & 16'h0020);
    i_host.wr(`ECL_OFS_WRAP3, 16'h0020);
    i_host.rd(`ECL_OFS_WRAP3, d);
    chk("wrap bit cleared", 16'h0000, d & 16'h0020);
    flag_pulse(3'b001);
    chk("wrap flag cleared", 16'h0, {15'h0, wrap_flag});
    // limit reached exactly on the second event
    limit_irq_en = 1'b1;
    i_host.set_limit(16'(tally_m + 2));
    i_host.rd(`ECL_OFS_LIMIT, d);
    chk("limit", 16'(tally_m + 2), d);
    pulse(5, 1'b1);
    chk("limit early", 16'h0, {15'h0, limit_flag});
    pulse(5, 1'b1);
    chk("limit flag", 16'h1, {15'h0, limit_flag});
    chk("limit irq", 16'h1, {15'h0, irq});
    // handover copies the tally, clears it and flips the bank
    bank0 = log_bank;
    i_host.wr(`ECL_OFS_HAND, 16'($urandom));
    i_host.rd(`ECL_OFS_SNAP, d);
    chk("snapshot", 16'(tally_m), d);
    tally_m = 0;
    i_host.rd(`ECL_OFS_TALLY, d);
    chk("tally cleared", 16'h0, d);
    chk("bank", {15'h0, ~bank0}, {15'h0, log_bank});
    v = 16'($urandom);
    i_host.wr(`ECL_OFS_SNAP, v);
    i_host.rd(`ECL_OFS_SNAP, d);
    chk("snapshot write", v, d);
    // tally at the last slot rolls over
    i_host.wr(`ECL_OFS_TALLY, 16'h0c00);
    tally_m = 3072;
    pulse(5, 1'b0);
    pulse(5, 1'b1);
    // stamp preset, refused in test mode, then runs to its maximum
    limit_irq_en = 1'b0;
    flag_pulse(3'b100);
    i_host.wr(`ECL_OFS_STAMP, 16'hfff0);
    i_host.rd(`ECL_OFS_STAMP, d);
    chk("stamp preset", 16'h1, {15'h0, (d - 16'hfff0) <= 16'h0002});
    test_mode = 1'b1;
    i_host.wr(`ECL_OFS_STAMP, 16'h0100);
    i_host.rd(`ECL_OFS_STAMP, d);
    chk("stamp test", 16'h1, {15'h0, (d - 16'hfff0) <= 16'h0005});
    test_mode = 1'b0;
    for (int k = 0; k < 200 && stamp_flag !== 1'b1; k++) @(posedge ref_clk);
    #1;
    chk("stamp flag", 16'h1, {15'h0, stamp_flag});
    chk("stamp irq off", 16'h0, {15'h0, irq});
    stamp_irq_en = 1'b1;
    #1;
    chk("stamp irq", 16'h1, {15'h0, irq});
    flag_pulse(3'b010);
    chk("stamp flag cleared", 16'h0, {15'h0, stamp_flag});
    // forced lamp ignores the control bit until reset
    i_host.wr(`ECL_OFS_LAMP, 16'($urandom));
    repeat (2) @(posedge ref_clk);
    #1;
    chk("lamp forced", 16'h1, {15'h0, lamp_on});
    lamp_ctrl = 1'b1;
    repeat (2) @(posedge ref_clk);
    #1;
    lamp_ctrl = 1'b0;
    repeat (3) @(posedge ref_clk);
    #1;
    chk("lamp held", 16'h1, {15'h0, lamp_on});
    arst_n = 1'b0;
    @(posedge ref_clk);
    #1;
    chk("lamp reset", 16'h0, {15'h0, lamp_on});
    arst_n = 1'b1;
    i_host.rd(`ECL_OFS_CNT_BASE + 12'h00a, d);
    chk("counter reset", 16'h0, d);
    conclude();
  end
endmodule
`default_nettype wire
